// [verilog/handoff_pkg.sv]
// shared constants and types for the converter result handoff
`default_nettype none
package handoff_pkg;
    localparam int RESULT_W        = 16;  // result register width
    localparam int DIV_W           = 4;   // clock divider field width
    localparam int CNT_W           = 8;   // cycle counter width
    localparam int DMA_READ_DELAY  = 3;   // earliest dma read after trigger, cycles
    localparam int DIV_THRESHOLD   = 2;   // divider above this exposes the hazard
    localparam int EARLY_FLAG_LEAD = 3;   // flag lead over latch in hazard case, cycles
    localparam int CONV_BASE       = 4;   // conversion cycles per divider step
    localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;
    typedef enum logic [2:0] {
        CONV_IDLE  = 3'b001,
        CONV_RUN   = 3'b010,
        CONV_LATCH = 3'b100
    } conv_state_t;
    typedef enum logic [3:0] {
        DMA_IDLE  = 4'b0001,
        DMA_WAIT  = 4'b0010,
        DMA_DUMMY = 4'b0100,
        DMA_READ  = 4'b1000
    } dma_state_t;
endpackage
`default_nettype wire

// [verilog/handoff_if.sv]
// link between converter and its dma consumer
`default_nettype none
interface handoff_if;
    logic                             conversion_done_flag;
    logic [handoff_pkg::RESULT_W-1:0] conversion_result_reg;
    logic                             result_read;
    modport converter (output conversion_done_flag, output conversion_result_reg,
                       input result_read);
    modport consumer  (input conversion_done_flag, input conversion_result_reg,
                       output result_read);
endinterface
`default_nettype wire

// [verilog/conv_result_end.sv]
// converter end: conversion timing, done flag and result register
// Summary of operation
// - done flag may precede result latch
// - dma may read three cycles after flag
// - three-cycle lead only late, 12-bit, divider>2
// - hazard needs late mode; early timing safe
// - stale only for idle dma direct read
// - dma uses dummy channel before real read
`default_nettype none
module conv_result_end #(
    parameter int LEAD = handoff_pkg::EARLY_FLAG_LEAD
) (
    // clock and reset
    input  wire logic                             MCLK,
    input  wire logic                             RESETN,
    // control
    input  wire logic                             START,
    input  wire logic                             LATE_MODE,
    input  wire logic                             RES_16BIT,
    input  wire logic [handoff_pkg::DIV_W-1:0]    CONVERTER_CLOCK_DIVIDER,
    input  wire logic [handoff_pkg::RESULT_W-1:0] SAMPLE,
    // status
    output logic                                  BUSY,
    // link
    handoff_if.converter                          link
);
    // elaboration checks: the flag slot must fit the shortest conversion,
    // and the counter must hold the longest one
    if (LEAD < 1 || LEAD >= handoff_pkg::CONV_BASE)
    begin
        $error("LEAD must lie in 1..CONV_BASE-1");
    end
    if (((2 ** handoff_pkg::DIV_W) * handoff_pkg::CONV_BASE) >= (2 ** handoff_pkg::CNT_W))
    begin
        $error("CNT_W too narrow for the longest conversion");
    end

    // counter constants at the counter's own width
    localparam logic [handoff_pkg::CNT_W-1:0] LEAD_C = handoff_pkg::CNT_W'(LEAD);
    localparam logic [handoff_pkg::CNT_W-1:0] ONE_C  = handoff_pkg::CNT_W'(1);
    localparam logic [handoff_pkg::CNT_W-1:0] ZERO_C = '0;

    // sequencer state
    handoff_pkg::conv_state_t             state, next_state;
    logic [handoff_pkg::CNT_W-1:0]        count, next_count;
    // per-conversion capture
    logic [handoff_pkg::CNT_W-1:0]        flag_at, next_flag_at;
    logic [handoff_pkg::RESULT_W-1:0]     sample_hold, next_sample_hold;
    // link-facing registers
    logic [handoff_pkg::RESULT_W-1:0]     result, next_result;
    logic                                 flag, next_flag;
    // strobes shared by the groups
    logic                                 take_start;
    logic                                 flag_slot;
    logic                                 latch_now;

    // hazard only when late, 12-bit and divider above threshold
    function automatic logic lead_case(input logic late, input logic r16,
                                       input logic [handoff_pkg::DIV_W-1:0] dv);
        lead_case = late && !r16 && (dv > handoff_pkg::DIV_W'(handoff_pkg::DIV_THRESHOLD));
    endfunction

    // count value that fires the flag; zero means together with the latch
    function automatic logic [handoff_pkg::CNT_W-1:0] flag_point(
        input logic late, input logic r16, input logic [handoff_pkg::DIV_W-1:0] dv);
        if (lead_case(late, r16, dv))
            flag_point = LEAD_C;
        else if (late)
            flag_point = ZERO_C;
        else
            flag_point = ONE_C;
    endfunction

    // conversion length grows with the divider setting
    function automatic logic [handoff_pkg::CNT_W-1:0] conv_length(
        input logic [handoff_pkg::DIV_W-1:0] dv);
        conv_length = handoff_pkg::CNT_W'((32'(dv) + 1) * handoff_pkg::CONV_BASE);
    endfunction

    // shared strobes; a start is only taken in idle, later ones are ignored
    assign take_start = (state == handoff_pkg::CONV_IDLE) && START;
    assign flag_slot  = (state == handoff_pkg::CONV_RUN) && (count == flag_at)
                        && (flag_at != ZERO_C);
    assign latch_now  = (state == handoff_pkg::CONV_LATCH);

    // sequencer: idle, count the conversion down, one latch cycle
    always_comb
    begin
        next_state = state;
        next_count = count;
        case (state)
            handoff_pkg::CONV_IDLE:
            begin
                if (take_start)
                begin
                    next_count = conv_length(CONVERTER_CLOCK_DIVIDER);
                    next_state = handoff_pkg::CONV_RUN;
                end
            end
            handoff_pkg::CONV_RUN:
            begin
                next_count = count - ONE_C;
                if (count == ONE_C)
                    next_state = handoff_pkg::CONV_LATCH;
            end
            handoff_pkg::CONV_LATCH:
                next_state = handoff_pkg::CONV_IDLE;
            default:
            begin
                next_state = handoff_pkg::CONV_IDLE;
                next_count = ZERO_C;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state <= handoff_pkg::CONV_IDLE;
            count <= ZERO_C;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
        end
    end

    // capture sample and flag slot at start, so mode changes mid-run move nothing
    always_comb
    begin
        next_sample_hold = sample_hold;
        next_flag_at     = flag_at;
        if (take_start)
        begin
            next_sample_hold = SAMPLE;
            next_flag_at     = flag_point(LATE_MODE, RES_16BIT, CONVERTER_CLOCK_DIVIDER);
        end
    end

    // capture registers
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            sample_hold <= handoff_pkg::RESULT_RESET;
            flag_at     <= ZERO_C;
        end
        else
        begin
            sample_hold <= next_sample_hold;
            flag_at     <= next_flag_at;
        end
    end

    // done flag: one-cycle pulse, ahead of the latch or on the latch edge
    always_comb
    begin
        next_flag = 1'b0;
        if (flag_slot)
            next_flag = 1'b1;
        else if (latch_now && flag_at == ZERO_C)
            next_flag = 1'b1;
    end

    // flag register
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            flag <= 1'b0;
        end
        else
        begin
            flag <= next_flag;
        end
    end

    // old word stays whole until the latch edge: an early reader gets stale
    // data but never a torn word
    always_comb
    begin
        next_result = result;
        if (latch_now)
            next_result = sample_hold;
    end

    // result register
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            result <= handoff_pkg::RESULT_RESET;
        end
        else
        begin
            result <= next_result;
        end
    end

    // link outputs straight from registers; busy is a decode of state
    assign link.conversion_done_flag  = flag;
    assign link.conversion_result_reg = result;
    assign BUSY = (state != handoff_pkg::CONV_IDLE);

endmodule
`default_nettype wire

// [verilog/dma_consumer_end.sv]
// consumer end: dma channel pair reading the result on the done flag
`default_nettype none
module dma_consumer_end (
    // clock and reset
    input  wire logic                             MCLK,
    input  wire logic                             RESETN,
    // control
    input  wire logic                             DUMMY_ENABLE,
    // result
    output logic [handoff_pkg::RESULT_W-1:0]      DATA,
    output logic                                  DATA_VALID,
    // link
    handoff_if.consumer                           link
);
    handoff_pkg::dma_state_t              state, next_state;
    logic [1:0]                           wait_cnt, next_wait_cnt;
    logic [handoff_pkg::RESULT_W-1:0]     data, next_data;
    logic                                 valid, next_valid;

    // trigger, fixed service latency, optional dummy, then the read
    always_comb
    begin
        next_state    = state;
        next_wait_cnt = wait_cnt;
        next_data     = data;
        next_valid    = 1'b0;
        case (state)
            handoff_pkg::DMA_IDLE:
                if (link.conversion_done_flag)
                begin
                    // flag seen, one wait cycle, read samples on the third edge, or on the fourth with the dummy
                    next_wait_cnt = 2'(handoff_pkg::DMA_READ_DELAY - 3);
                    next_state    = handoff_pkg::DMA_WAIT;
                end
            handoff_pkg::DMA_WAIT:
                if (wait_cnt == 2'h0)
                    next_state = DUMMY_ENABLE ? handoff_pkg::DMA_DUMMY
                                              : handoff_pkg::DMA_READ;
                else
                    next_wait_cnt = wait_cnt - 2'h1;
            handoff_pkg::DMA_DUMMY:
                next_state = handoff_pkg::DMA_READ;
            handoff_pkg::DMA_READ:
            begin
                next_data  = link.conversion_result_reg;
                next_valid = 1'b1;
                next_state = handoff_pkg::DMA_IDLE;
            end
            default:
                next_state = handoff_pkg::DMA_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state    <= handoff_pkg::DMA_IDLE;
            wait_cnt <= 2'h0;
            data     <= handoff_pkg::RESULT_RESET;
            valid    <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            wait_cnt <= next_wait_cnt;
            data     <= next_data;
            valid    <= next_valid;
        end
    end

    assign link.result_read = (state == handoff_pkg::DMA_READ);
    assign DATA       = data;
    assign DATA_VALID = valid;
endmodule
`default_nettype wire

// [bench/handoff_monitor.sv]
// concurrent checks on the converter to consumer link
`default_nettype none
module handoff_monitor (
    // clock and reset
    input  wire logic                             MCLK,
    input  wire logic                             RESETN,
    // link signals
    input  wire logic                             conversion_done_flag,
    input  wire logic [handoff_pkg::RESULT_W-1:0] conversion_result_reg,
    input  wire logic                             result_read
);
    timeunit 1ns;
    timeprecision 100ps;
    // short aliases keep the properties readable
    wire                             flg = conversion_done_flag;
    wire                             rd  = result_read;
    wire [handoff_pkg::RESULT_W-1:0] res = conversion_result_reg;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    chk_flag_lone_pulse: assert property (flg |=> (!flg) [*3])
        else $error("done flag not a lone pulse");
    chk_latch_near_flag: assert property ($changed(res) |->
        flg || $past(flg) || $past(flg, 2) || $past(flg, 3)) else $error("latch far from flag");
    chk_flag_then_latch: assert property (flg |-> ##[0:3] $changed(res))
        else $error("no latch within three cycles of flag");
    chk_result_whole_hold: assert property ($changed(res) |=> $stable(res) [*3])
        else $error("result word not held");
    chk_read_after_flag: assert property (rd |-> $past(flg, 2) || $past(flg, 3))
        else $error("read not two or three cycles after flag");
    chk_flag_gets_read: assert property (flg |-> ##[2:3] rd)
        else $error("flag not followed by a read");
    chk_read_single: assert property (rd |=> !rd)
        else $error("more than one read per flag");
    chk_flagless_read: assert property (rd |-> !flg)
        else $error("flag during read");
endmodule
`default_nettype wire

// [bench/test_adc_result_dma_handoff.sv]
// self-checking bench for the converter result handoff
`default_nettype none
module test_adc_result_dma_handoff;
    timeunit 1ns;
    timeprecision 100ps;
    logic                             MCLK   = 1'b0;
    logic                             RESETN = 1'b0;
    logic                             start  = 1'b0;
    logic                             late   = 1'b0;
    logic                             res16  = 1'b0;
    logic                             dummy  = 1'b0;
    logic [handoff_pkg::DIV_W-1:0]    div    = 4'h0;
    logic [handoff_pkg::RESULT_W-1:0] sample = 16'h0000;
    logic [handoff_pkg::RESULT_W-1:0] prev;
    logic [handoff_pkg::RESULT_W-1:0] data;
    logic [handoff_pkg::RESULT_W-1:0] exp_v;
    logic [handoff_pkg::RESULT_W-1:0] exp_q[$];
    logic                             valid;
    logic                             busy;
    int                               errors = 0;
    int                               checks_done = 0;
    // mode table: late, 16-bit, divider, dummy channel
    localparam logic [6:0] CASES [8] = '{7'h46, 7'h47, 7'h5E, 7'h44, 7'h6A, 7'h0A, 7'h01, 7'h40};
    handoff_if link ();
    conv_result_end u_conv_result_end (.MCLK(MCLK), .RESETN(RESETN), .START(start),
        .LATE_MODE(late), .RES_16BIT(res16), .CONVERTER_CLOCK_DIVIDER(div),
        .SAMPLE(sample), .BUSY(busy), .link(link));
    dma_consumer_end u_dma_consumer_end (.MCLK(MCLK), .RESETN(RESETN),
        .DUMMY_ENABLE(dummy), .DATA(data), .DATA_VALID(valid), .link(link));
    handoff_monitor u_handoff_monitor (.MCLK(MCLK), .RESETN(RESETN),
        .conversion_done_flag(link.conversion_done_flag),
        .conversion_result_reg(link.conversion_result_reg), .result_read(link.result_read));
    always #12.5 MCLK = ~MCLK;
    // one conversion; stale only when the flag leads the latch by three cycles and no dummy read pads the wait
    task automatic convert(input logic l, input logic r, input logic [handoff_pkg::DIV_W-1:0] d,
                           input logic dm);
        int n;
        @(posedge MCLK);
        #2;
        late  = l;
        res16 = r;
        div   = d;
        dummy = dm;
        prev  = sample;
        @(posedge MCLK);
        #2;
        sample = prev ^ 16'($urandom_range(16'h0001, 16'hFFFF)); // new value always differs
        start  = 1'b1;
        exp_q.push_back((l && !r && d > handoff_pkg::DIV_W'(handoff_pkg::DIV_THRESHOLD) && !dm)
                        ? prev : sample);
        @(posedge MCLK);
        #2;
        start = 1'b0;
        checks_done++;
        if (busy !== 1'b1)
        begin
            errors++;
            $display("[ERR] BUSY expected 1 seen %b", busy);
        end
        for (n = 0; n < 300 && (exp_q.size() != 0 || busy !== 1'b0); n++) @(posedge MCLK);
        if (n >= 300)
        begin
            errors++;
            $display("[ERR] DATA_VALID expected pulse seen none");
        end
    endtask
    // watcher: oldest note against each delivered word
    always @(posedge MCLK)
    begin
        if (valid === 1'b1)
        begin
            checks_done++;
            if (exp_q.size() == 0)
            begin
                errors++;
                $display("[ERR] DATA expected none seen %h", data);
            end
            else
            begin
                exp_v = exp_q.pop_front();
                if (data !== exp_v)
                begin
                    errors++;
                    $display("[ERR] DATA expected %h seen %h", exp_v, data);
                end
            end
        end
    end
    task automatic stop_test();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // watchdog well beyond fourteen slowest conversions
    initial
    begin
        #(25 * 4000);
        errors++;
        $display("[ERR] run expected done seen hang");
        stop_test();
    end
    initial
    begin
        void'($urandom(19));
        repeat (8) @(posedge MCLK);
        #2;
        RESETN = 1'b1;
        foreach (CASES[i]) convert(CASES[i][6], CASES[i][5], CASES[i][4:1], CASES[i][0]);
        repeat (6) convert(1'($urandom_range(0, 1)), 1'($urandom_range(0, 1)),
            4'($urandom_range(0, 15)), 1'($urandom_range(0, 1)));
        stop_test();
    end
endmodule
`default_nettype wire
